// ==== common/cpo_pkg.sv ====
// cpo_pkg: constants shared by the pixel output correction core and its even-odd stage.
// assumes one clock (the converter clock) and an AXI4-Lite register port with 32-bit data.
package cpo_pkg;
  // pixel and register widths
  localparam int          CPO_DATA_W      = 10;
  localparam int          CPO_GAIN_W      = 10;
  localparam int          CPO_AUX_W       = 8;
  localparam int          CPO_TARGET_W    = 7;
  localparam int          CPO_OFFSET_W    = 12;
  localparam int          CPO_ADDR_W      = 8;
  localparam int          CPO_BUS_W       = 32;
  // register byte offsets
  localparam logic [7:0]  CPO_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  CPO_OFF_GAIN    = 8'h04;
  localparam logic [7:0]  CPO_OFF_AUX1    = 8'h08;
  localparam logic [7:0]  CPO_OFF_AUX2    = 8'h0C;
  localparam logic [7:0]  CPO_OFF_STATUS  = 8'h10;
  localparam logic [7:0]  CPO_OFF_OFFSETS = 8'h14;
  // control register fields
  localparam int          CPO_CLAMP_LSB   = 0;
  localparam int          CPO_CORR_DIS    = 2;
  localparam int          CPO_GAIN_SRC    = 3;
  // reset values
  localparam logic [1:0]  CPO_CLAMP_RST   = 2'h0;
  localparam logic        CPO_CORR_RST    = 1'b0;
  localparam logic        CPO_SRC_RST     = 1'b0;
  localparam logic [9:0]  CPO_GAIN_RST    = 10'h000;
  localparam logic [7:0]  CPO_AUX_RST     = 8'h00;
  // pipeline latencies in converter clocks
  localparam int          CPO_LAT_BYPASS  = 5;
  localparam int          CPO_LAT_EXTRA   = 2;
  // black averaging weight as a shift
  localparam int          CPO_AVG_SHIFT   = 3;
  // bus responses
  localparam logic [1:0]  CPO_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CPO_RESP_SLVERR = 2'h2;

  // clamp level code to black target in output codes
  function automatic logic [6:0] cpo_clamp_target(input logic [1:0] code);
    unique case (code)
      2'h0: cpo_clamp_target = 7'h20;
      2'h1: cpo_clamp_target = 7'h30;
      2'h2: cpo_clamp_target = 7'h40;
      2'h3: cpo_clamp_target = 7'h10;
    endcase
  endfunction : cpo_clamp_target
endpackage : cpo_pkg

// ==== core/cpo_eo_corr.sv ====
// cpo_eo_corr: even-odd black tracking and two-stage offset correction.
// assumes pixels arrive one per clock tagged with channel parity and a black flag.
`timescale 1ns/10ps
`default_nettype none
module cpo_eo_corr
  import cpo_pkg::*;
#(
  parameter int DATA_W = CPO_DATA_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [DATA_W-1:0] in_data,
  input  wire logic              in_odd,
  input  wire logic              in_black,
  output logic      [DATA_W-1:0] out_data,
  output logic      [DATA_W:0]   corr_value
);
  localparam int ACC_W = DATA_W + CPO_AVG_SHIFT;

  logic [ACC_W-1:0]  acc_even;
  logic [ACC_W-1:0]  acc_odd;
  logic [DATA_W-1:0] s1_data;
  logic              s1_odd;
  logic [DATA_W+1:0] sum;

  // elaboration check
  if (DATA_W < 4 || DATA_W > 16) begin : g_bad_width
    $error("cpo_eo_corr: DATA_W out of range");
  end

  // leaky average of black pixels per channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_even <= '0;
      acc_odd  <= '0;
    end else if (in_black) begin
      if (in_odd) begin
        acc_odd <= acc_odd - (acc_odd >> CPO_AVG_SHIFT) + ACC_W'(in_data);
      end else begin
        acc_even <= acc_even - (acc_even >> CPO_AVG_SHIFT) + ACC_W'(in_data);
      end
    end
  end

  // first stage: capture pixel and current balance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_data    <= '0;
      s1_odd     <= 1'b0;
      corr_value <= '0;
    end else begin
      s1_data    <= in_data;
      s1_odd     <= in_odd;
      corr_value <= (DATA_W+1)'(acc_even[ACC_W-1:CPO_AVG_SHIFT])
                  - (DATA_W+1)'(acc_odd[ACC_W-1:CPO_AVG_SHIFT]);
    end
  end

  always_comb begin
    sum = (DATA_W+2)'(s1_data) + (s1_odd ? {corr_value[DATA_W], corr_value} : '0);
  end

  // second stage: odd pixels shifted onto even black, saturated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data <= '0;
    end else if (sum[DATA_W+1]) begin
      out_data <= '0;
    end else if (sum[DATA_W]) begin
      out_data <= '1;
    end else begin
      out_data <= sum[DATA_W-1:0];
    end
  end
endmodule : cpo_eo_corr
`default_nettype wire

// ==== core/cpo_core.sv ====
// cpo_core: pixel output stage of the ccd processor with AXI4-Lite control registers.
// assumes aclk is the converter clock and all strobes are synchronous to it.
//
// Behaviour
// - black clamp strobe low runs black loop driving black pixels toward target.
// - black target selectable by software among 16, 32, 48 and 64 codes.
// - clamp field 00=32, 01=48, 10=64, 11=16 codes; resets to 00.
// - input bias clamp low closes the input bias loop.
// - pixel blanking low halts sampling and disconnects the inputs.
// - pixel output is all zero while pixel blanking is low.
// - pixels alternate between two sampling channels, ping-pong.
// - digital stage tracks even and odd black separately and balances them.
// - correction adds two clocks, total latency seven clocks.
// - correction disable bit: 0 corrects, 1 bypasses; resets to 0.
// - output data updates on the converter clock.
// - gain settable from an internal 10-bit code over the same range.
// - gain source bit: 0 external inputs, 1 internal code; resets to 0.
// - two independent 8-bit auxiliary converter codes held from software.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cpo_core
  import cpo_pkg::*;
#(
  parameter int DATA_W = CPO_DATA_W,
  parameter int LAT    = CPO_LAT_BYPASS
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // register bus
  input  wire logic [CPO_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [CPO_BUS_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [CPO_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [CPO_BUS_W-1:0]         s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // converter side
  input  wire logic [DATA_W-1:0]       adc_data,
  input  wire logic                    black_clamp_strobe_n,
  input  wire logic                    input_bias_clamp_n,
  input  wire logic                    pixel_blank_n,
  input  wire logic                    ref_sample_strobe,
  input  wire logic                    data_sample_strobe,
  input  wire logic [CPO_GAIN_W-1:0]   coarse_gain_input,
  input  wire logic [CPO_GAIN_W-1:0]   fine_gain_input,
  // outputs
  output logic [DATA_W-1:0]            pixel_out,
  output logic                         cds_run,
  output logic                         input_connect,
  output logic                         bias_loop_close,
  output logic                         sample_channel_odd,
  output logic [CPO_OFFSET_W-1:0]      black_offset_even,
  output logic [CPO_OFFSET_W-1:0]      black_offset_odd,
  output logic [CPO_GAIN_W-1:0]        gain_coarse_code,
  output logic [CPO_GAIN_W-1:0]        gain_fine_code,
  output logic [CPO_AUX_W-1:0]         aux1_code,
  output logic [CPO_AUX_W-1:0]         aux2_code
);
  localparam int PW = DATA_W + 2;

  // elaboration check: target fits the pixel, status fields must not overlap
  if (DATA_W < 7 || DATA_W > 15 || LAT < 1) begin : g_bad_param
    $error("cpo_core: DATA_W or LAT out of range");
  end

  // registers
  logic [1:0]           clamp_level;
  logic                 correction_disable;
  logic                 gain_source_select;
  logic [CPO_GAIN_W-1:0] gain_code;

  // bus state
  logic                  aw_full;
  logic                  w_full;
  logic [CPO_ADDR_W-1:0] aw_addr;
  logic [CPO_BUS_W-1:0]  w_data;
  logic [3:0]            w_strb;
  logic                  do_write;
  logic                  wr_hit;

  // pipeline
  logic [PW-1:0]         pipe [LAT];
  logic                  ref_seen;
  logic                  data_strobe_q;
  logic [DATA_W-1:0]     corr_data;
  logic [DATA_W:0]       corr_value;
  logic [DATA_W-1:0]     tap_data;
  logic                  tap_odd;
  logic                  tap_black;
  logic [CPO_TARGET_W-1:0] black_target;
  logic [CPO_BUS_W-1:0]  next_rdata;
  logic                  rd_hit;

  // write channel acceptance
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign do_write      = aw_full && w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    wr_hit = (aw_addr == CPO_OFF_CTRL) || (aw_addr == CPO_OFF_GAIN)
          || (aw_addr == CPO_OFF_AUX1) || (aw_addr == CPO_OFF_AUX2)
          || (aw_addr == CPO_OFF_STATUS) || (aw_addr == CPO_OFF_OFFSETS);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= {s_axi_awaddr[CPO_ADDR_W-1:2], 2'h0};
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CPO_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? CPO_RESP_OKAY : CPO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clamp_level        <= CPO_CLAMP_RST;
      correction_disable <= CPO_CORR_RST;
      gain_source_select <= CPO_SRC_RST;
      gain_code          <= CPO_GAIN_RST;
      aux1_code          <= CPO_AUX_RST;
      aux2_code          <= CPO_AUX_RST;
    end else if (do_write) begin
      if (aw_addr == CPO_OFF_CTRL && w_strb[0]) begin
        clamp_level        <= w_data[CPO_CLAMP_LSB +: 2];
        correction_disable <= w_data[CPO_CORR_DIS];
        gain_source_select <= w_data[CPO_GAIN_SRC];
      end
      if (aw_addr == CPO_OFF_GAIN) begin
        if (w_strb[0]) gain_code[7:0] <= w_data[7:0];
        if (w_strb[1]) gain_code[CPO_GAIN_W-1:8] <= w_data[CPO_GAIN_W-1:8];
      end
      if (aw_addr == CPO_OFF_AUX1 && w_strb[0]) aux1_code <= w_data[CPO_AUX_W-1:0];
      if (aw_addr == CPO_OFF_AUX2 && w_strb[0]) aux2_code <= w_data[CPO_AUX_W-1:0];
    end
  end

  // read path
  always_comb begin
    next_rdata = '0;
    rd_hit     = 1'b1;
    unique case ({s_axi_araddr[CPO_ADDR_W-1:2], 2'h0})
      CPO_OFF_CTRL: begin
        next_rdata[CPO_CLAMP_LSB +: 2] = clamp_level;
        next_rdata[CPO_CORR_DIS]       = correction_disable;
        next_rdata[CPO_GAIN_SRC]       = gain_source_select;
      end
      CPO_OFF_GAIN:    next_rdata[CPO_GAIN_W-1:0] = gain_code;
      CPO_OFF_AUX1:    next_rdata[CPO_AUX_W-1:0]  = aux1_code;
      CPO_OFF_AUX2:    next_rdata[CPO_AUX_W-1:0]  = aux2_code;
      CPO_OFF_STATUS: begin
        next_rdata[DATA_W:0]        = corr_value;
        next_rdata[16 +: CPO_TARGET_W] = black_target;
        next_rdata[24]              = sample_channel_odd;
        next_rdata[25]              = cds_run;
      end
      CPO_OFF_OFFSETS: begin
        next_rdata[CPO_OFFSET_W-1:0]  = black_offset_even;
        next_rdata[16 +: CPO_OFFSET_W] = black_offset_odd;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= CPO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_hit ? CPO_RESP_OKAY : CPO_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // front-end controls
  assign black_target    = cpo_clamp_target(clamp_level);
  assign cds_run         = pixel_blank_n;
  assign input_connect   = pixel_blank_n;
  assign bias_loop_close = !input_bias_clamp_n;
  assign gain_coarse_code = gain_source_select ? gain_code : coarse_gain_input;
  assign gain_fine_code   = gain_source_select ? '0 : fine_gain_input;

  // ping-pong channel advances on each data sample after a reference sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_strobe_q      <= 1'b0;
      ref_seen           <= 1'b0;
      sample_channel_odd <= 1'b0;
    end else begin
      data_strobe_q <= data_sample_strobe;
      if (!pixel_blank_n) begin
        ref_seen <= 1'b0;
      end else if (ref_sample_strobe) begin
        ref_seen <= 1'b1;
      end else if (data_sample_strobe && !data_strobe_q && ref_seen) begin
        ref_seen           <= 1'b0;
        sample_channel_odd <= !sample_channel_odd;
      end
    end
  end

  // delay line: black flag, channel, pixel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LAT; i++) pipe[i] <= '0;
    end else begin
      pipe[0] <= {!black_clamp_strobe_n, sample_channel_odd, adc_data};
      for (int i = 1; i < LAT; i++) pipe[i] <= pipe[i-1];
    end
  end

  assign tap_black = pipe[LAT-1][PW-1];
  assign tap_odd   = pipe[LAT-1][PW-2];
  assign tap_data  = pipe[LAT-1][DATA_W-1:0];

  // black loop: per-channel integrators toward the target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      black_offset_even <= '0;
      black_offset_odd  <= '0;
    end else if (tap_black) begin
      if (tap_odd) begin
        if (tap_data > DATA_W'(black_target)) black_offset_odd <= black_offset_odd - 1'b1;
        else if (tap_data < DATA_W'(black_target)) black_offset_odd <= black_offset_odd + 1'b1;
      end else begin
        if (tap_data > DATA_W'(black_target)) black_offset_even <= black_offset_even - 1'b1;
        else if (tap_data < DATA_W'(black_target)) black_offset_even <= black_offset_even + 1'b1;
      end
    end
  end

  cpo_eo_corr #(
    .DATA_W     (DATA_W)
  ) u_eo_corr (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .in_data    (tap_data),
    .in_odd     (tap_odd),
    .in_black   (tap_black),
    .out_data   (corr_data),
    .corr_value (corr_value)
  );

  // output select and blanking
  always_comb begin
    if (!pixel_blank_n) begin
      pixel_out = '0;
    end else if (correction_disable) begin
      pixel_out = tap_data;
    end else begin
      pixel_out = corr_data;
    end
  end
endmodule : cpo_core
`default_nettype wire

// ==== testbench/cpo_tgen.sv ====
// cpo_tgen: timing generator model, pixel counter and sample strobes.
// assumes one pixel per aclk; strobes alternate reference then data.
`timescale 1ns/10ps
`default_nettype none
module cpo_tgen
  import cpo_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  hold_level,
  input  wire logic [CPO_DATA_W-1:0] level,
  output logic      [CPO_DATA_W-1:0] adc_data,
  output logic                       ref_sample_strobe,
  output logic                       data_sample_strobe
);
  logic                  phase = 1'b0;
  logic [CPO_DATA_W-1:0] count = '0;
  // reference strobe, then data strobe, each pixel pair
  always @(posedge aclk) begin
    phase <= ~phase;
    ref_sample_strobe <= ~phase;
    data_sample_strobe <= phase;
    count <= count + 10'h001;
    adc_data <= hold_level ? level : count;
  end
endmodule : cpo_tgen
`default_nettype wire

// ==== testbench/cpo_core_chk.sv ====
// cpo_core_chk: port checks of cpo_core.
// assumes a bind into cpo_core; one clock, sync active-low reset.
`timescale 1ns/10ps
`default_nettype none
module cpo_core_chk
  import cpo_pkg::*;
#(
  parameter int DATA_W = CPO_DATA_W
) (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [CPO_BUS_W-1:0]    s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic                    pixel_blank_n,
  input wire logic                    input_bias_clamp_n,
  input wire logic                    data_sample_strobe,
  input wire logic [CPO_GAIN_W-1:0]   fine_gain_input,
  input wire logic [DATA_W-1:0]       pixel_out,
  input wire logic                    cds_run,
  input wire logic                    input_connect,
  input wire logic                    bias_loop_close,
  input wire logic                    sample_channel_odd,
  input wire logic [CPO_OFFSET_W-1:0] black_offset_even,
  input wire logic [CPO_GAIN_W-1:0]   gain_fine_code,
  input wire logic [CPO_AUX_W-1:0]    aux1_code,
  input wire logic [CPO_AUX_W-1:0]    aux2_code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    ##[1:3] s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
    else $error("write not answered");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_blank_zero: assert property (!pixel_blank_n |-> pixel_out == '0)
    else $error("output not zero in blanking");
  a_cds_halt: assert property (cds_run == pixel_blank_n && input_connect == pixel_blank_n)
    else $error("sampling not halted by blanking");
  a_bias_loop: assert property (bias_loop_close == !input_bias_clamp_n)
    else $error("bias loop state wrong");
  a_chan_steady: assert property (!$rose(data_sample_strobe) |=> $stable(sample_channel_odd))
    else $error("channel moved without data strobe");
  a_black_step: assert property ($changed(black_offset_even) |->
    (black_offset_even - $past(black_offset_even)) inside {12'h001, 12'hFFF})
    else $error("black loop step not one");
  a_fine_gate: assert property (gain_fine_code == fine_gain_input || gain_fine_code == '0)
    else $error("fine gain source wrong");
  a_aux_update: assert property ($changed(aux1_code) || $changed(aux2_code) |-> $rose(s_axi_bvalid))
    else $error("aux code changed without write");
endmodule : cpo_core_chk
`default_nettype wire

// ==== testbench/tb_top.sv ====
// tb_top: register, gain, latency, blanking and black loop tests of cpo_core.
// assumes cpo_tgen supplies pixels and strobes; checker bound at the foot.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cpo_pkg::*;
  logic                    aclk, aresetn, hold_level, ch;
  logic [CPO_ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [CPO_BUS_W-1:0]    s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]              s_axi_wstrb;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                    s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]              s_axi_bresp, s_axi_rresp, rs;
  logic [CPO_DATA_W-1:0]   adc_data, pixel_out, level;
  logic                    black_clamp_strobe_n, input_bias_clamp_n, pixel_blank_n, ref_sample_strobe;
  logic                    data_sample_strobe, cds_run, input_connect, bias_loop_close, sample_channel_odd;
  logic [CPO_GAIN_W-1:0]   coarse_gain_input, fine_gain_input, gain_coarse_code, gain_fine_code;
  logic [CPO_OFFSET_W-1:0] black_offset_even, black_offset_odd;
  logic [CPO_AUX_W-1:0]    aux1_code, aux2_code;
  logic [CPO_DATA_W-1:0]   hist [0:8191];
  logic [7:0]              roff [0:3] = '{CPO_OFF_CTRL, CPO_OFF_GAIN, CPO_OFF_AUX1, CPO_OFF_AUX2};
  logic [6:0]              tgt [0:3] = '{7'h20, 7'h30, 7'h40, 7'h10};
  int                      ncyc = 0, errors = 0, compares = 0;

  cpo_core cpo_core_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .adc_data(adc_data), .black_clamp_strobe_n(black_clamp_strobe_n),
    .input_bias_clamp_n(input_bias_clamp_n), .pixel_blank_n(pixel_blank_n),
    .ref_sample_strobe(ref_sample_strobe), .data_sample_strobe(data_sample_strobe),
    .coarse_gain_input(coarse_gain_input), .fine_gain_input(fine_gain_input), .pixel_out(pixel_out),
    .cds_run(cds_run), .input_connect(input_connect), .bias_loop_close(bias_loop_close),
    .sample_channel_odd(sample_channel_odd), .black_offset_even(black_offset_even),
    .black_offset_odd(black_offset_odd), .gain_coarse_code(gain_coarse_code),
    .gain_fine_code(gain_fine_code), .aux1_code(aux1_code), .aux2_code(aux2_code)
  );
  cpo_tgen cpo_tgen_i (
    .aclk(aclk), .hold_level(hold_level), .level(level), .adc_data(adc_data),
    .ref_sample_strobe(ref_sample_strobe), .data_sample_strobe(data_sample_strobe)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // pixel sampled at each rising edge, for latency checks
  always @(posedge aclk) begin
    hist[ncyc] = adc_data;
    ncyc = ncyc + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic lat_test(input int lat);
    repeat (12) @(negedge aclk);
    repeat (8) begin
      @(negedge aclk);
      check(pixel_out, hist[ncyc-lat]);
    end
    $display("test latency %0d done", lat);
  endtask : lat_test

  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  initial begin
    #20000;
    errors++;
    test_done();
  end

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    black_clamp_strobe_n = 1'b1;
    input_bias_clamp_n = 1'b1;
    pixel_blank_n = 1'b1;
    hold_level = 1'b0;
    level = '0;
    coarse_gain_input = 10'h155;
    fine_gain_input = 10'h0AA;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      axi_read(roff[i]);
      check(rd, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      axi_write(CPO_OFF_CTRL, 32'(i));
      axi_read(CPO_OFF_STATUS);
      check(rd[22:16], tgt[i]);
    end
    $display("test reset and clamp done");
    check(gain_coarse_code, coarse_gain_input);
    check(gain_fine_code, fine_gain_input);
    axi_write(CPO_OFF_GAIN, 32'h0000_02A5);
    axi_write(CPO_OFF_CTRL, 32'h0000_0008);
    check(gain_coarse_code, 10'h2A5);
    check(gain_fine_code, 10'h000);
    axi_write(CPO_OFF_AUX1, 32'h0000_00A5);
    axi_write(CPO_OFF_AUX2, 32'h0000_003C);
    check(aux1_code, 8'hA5);
    check(aux2_code, 8'h3C);
    axi_read(CPO_OFF_AUX2);
    check(rd, 32'h3C);
    axi_write(8'h40, 32'h1);
    check(rs, CPO_RESP_SLVERR);
    axi_read(8'h40);
    check(rs, CPO_RESP_SLVERR);
    $display("test gain and aux done");
    axi_write(CPO_OFF_CTRL, 32'h0000_0004);
    lat_test(CPO_LAT_BYPASS);
    axi_write(CPO_OFF_CTRL, 32'h0000_0000);
    lat_test(CPO_LAT_BYPASS + CPO_LAT_EXTRA);
    @(posedge aclk);
    pixel_blank_n <= 1'b0;
    input_bias_clamp_n <= 1'b0;
    repeat (4) begin
      @(negedge aclk);
      check(pixel_out, 0);
      check({cds_run, input_connect}, 0);
      check(bias_loop_close, 1);
    end
    @(posedge aclk);
    pixel_blank_n <= 1'b1;
    input_bias_clamp_n <= 1'b1;
    repeat (4) @(negedge aclk);
    repeat (6) begin
      @(negedge aclk);
      ch = sample_channel_odd;
      repeat (2) @(negedge aclk);
      check(sample_channel_odd, !ch);
    end
    $display("test blanking and channels done");
    @(posedge aclk);
    hold_level <= 1'b1;
    black_clamp_strobe_n <= 1'b0;
    repeat (60) @(posedge aclk);
    check(black_offset_even != 12'h000, 1);
    check(black_offset_odd != 12'h000, 1);
    black_clamp_strobe_n <= 1'b1;
    hold_level <= 1'b0;
    $display("test black loop done");
    test_done();
  end
endmodule : tb_top

bind cpo_core cpo_core_chk #(.DATA_W(DATA_W)) cpo_core_chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pixel_blank_n(pixel_blank_n), .input_bias_clamp_n(input_bias_clamp_n),
  .data_sample_strobe(data_sample_strobe), .fine_gain_input(fine_gain_input), .pixel_out(pixel_out),
  .cds_run(cds_run), .input_connect(input_connect), .bias_loop_close(bias_loop_close),
  .sample_channel_odd(sample_channel_odd), .black_offset_even(black_offset_even),
  .gain_fine_code(gain_fine_code), .aux1_code(aux1_code), .aux2_code(aux2_code)
);
`default_nettype wire
